// ==== design/pin_sync.sv ====
// Purpose: Two-flop synchroniser with rising-edge detect for a pin
// Assumes: Pin is asynchronous to sys_clk
// Notes: Edge detect looks only at the second and third flops
`timescale 1ns/10ps
module pin_sync
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic pin_in,
   output logic level,
   output logic rise
);
   logic meta_r;
   logic level_r;
   logic prev_r;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         meta_r <= 1'b0;
         level_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         meta_r <= pin_in;
         level_r <= meta_r;
         prev_r <= level_r;
      end
   end

   assign level = level_r;
   assign rise = level_r & ~prev_r;
endmodule // pin_sync

// ==== design/sysclk_standby_config.sv ====
// Purpose: Clock source, warm-up, standby mode and clock-output configuration
// Assumes: Avalon-MM word addressing, byte lane 0 carries the register image
// Notes: Core wait and latch requests come from sys_clk logic; pins are synchronised
`timescale 1ns/10ps
`include "sysclk_standby_map.svh"
module sysclk_standby_config
#(
   parameter logic [16:0] warmup_ticks_mid = `WARMUP_TICKS_MID,
   parameter logic [16:0] warmup_ticks_long = `WARMUP_TICKS_LONG
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [31:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic core_wait,
   input wire logic core_low_power_bit,
   input wire logic wake_pin,
   input wire logic fast_osc_clk_pin,
   input wire logic slow_osc_clk_pin,
   input wire logic prescaler_base_clock,
   input wire logic latch_req,
   output logic fast_osc_run,
   output logic slow_osc_run,
   output logic fast_osc_low_drive,
   output logic sysclk_source_sel,
   output logic cpu_halted,
   output logic periph_halted,
   output logic pins_drive_en,
   output logic clock_output_pin,
   output logic latch_strobe
);
   sysclk_standby_pkg::standby_cfg_type stby_r, stby_nxt;
   sysclk_standby_pkg::clkout_cfg_type clk_r, clk_nxt;
   sysclk_standby_pkg::osc_cfg_type osc_r, osc_nxt;
   sysclk_standby_pkg::power_state_type state_r, state_nxt;
   logic wait_r, wait_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wr_take;
   logic sw_start;
   logic stop_release;
   logic warm_start;
   logic warm_slow_r, warm_slow_nxt;
   logic warm_busy;
   logic wake_rise, fast_rise, slow_rise, slow_level;
   logic [1:0] div_r, div_nxt;
   logic [1:0] latch_cnt_r, latch_cnt_nxt;
   logic fast_run_r, slow_run_r, drive_r, cpu_halt_r, periph_halt_r;
   logic pins_en_r, clkout_r, strobe_r;
   logic fast_run_nxt, slow_run_nxt, pins_en_nxt, clkout_nxt;

   pin_sync u_wake_sync
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin_in(wake_pin),
      .level(),
      .rise(wake_rise)
   );

   pin_sync u_fast_sync
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin_in(fast_osc_clk_pin),
      .level(),
      .rise(fast_rise)
   );

   pin_sync u_slow_sync
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin_in(slow_osc_clk_pin),
      .level(slow_level),
      .rise(slow_rise)
   );

   warmup_timer #(.ticks_mid(warmup_ticks_mid), .ticks_long(warmup_ticks_long)) u_warmup
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .start(warm_start),
      .len(stby_r.warmup_len),
      .tick(warm_slow_r ? slow_rise : fast_rise),
      .warm_busy(warm_busy)
   );

   // Register image as software sees it; reserved fields are never stored as 1
   function automatic logic [7:0] reg_image(input logic [31:0] addr);
      case (addr)
         `STBY_CTRL_IDX: reg_image = stby_r;
         `CLKOUT_CTRL_IDX: reg_image = clk_r;
         `OSC_RUN_CTRL_IDX: reg_image = osc_r | {5'h00, warm_busy, 2'h0};
         default: reg_image = 8'h00;
      endcase
   endfunction

   // Bus slave: one wait cycle, then the answer stands for one edge
   always_comb
   begin
      wait_nxt = !((avs_read || avs_write) && wait_r);
      rdata_nxt = rdata_r;
      if (avs_read && wait_r)
         rdata_nxt = {24'h000000, reg_image(avs_address)};
      wr_take = avs_write && !wait_r && avs_byteenable[0];
      sw_start = wr_take && (avs_address == `OSC_RUN_CTRL_IDX) &&
         avs_writedata[`OSC_WARM_FLAG_BIT];
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         wait_r <= 1'b1;
         rdata_r <= 32'h00000000;
      end
      else
      begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Power mode sequencing
   always_comb
   begin
      state_nxt = state_r;
      stop_release = 1'b0;
      unique case (state_r)
         sysclk_standby_pkg::st_run:
         begin
            if (core_wait && core_low_power_bit)
            begin
               unique case (stby_r.standby_sel)
                  sysclk_standby_pkg::sb_stop: state_nxt = sysclk_standby_pkg::st_stop;
                  sysclk_standby_pkg::sb_sleep: state_nxt = sysclk_standby_pkg::st_sleep;
                  sysclk_standby_pkg::sb_idle: state_nxt = sysclk_standby_pkg::st_idle;
                  sysclk_standby_pkg::sb_reserved: state_nxt = sysclk_standby_pkg::st_run;
               endcase
            end
         end
         sysclk_standby_pkg::st_idle, sysclk_standby_pkg::st_sleep:
         begin
            if (wake_rise)
               state_nxt = sysclk_standby_pkg::st_run;
         end
         sysclk_standby_pkg::st_stop:
         begin
            if (wake_rise)
            begin
               state_nxt = sysclk_standby_pkg::st_restart;
               stop_release = 1'b1;
            end
         end
         sysclk_standby_pkg::st_restart:
         begin
            // Timer was started on the release edge, so busy is already valid
            if (!warm_busy)
               state_nxt = sysclk_standby_pkg::st_run;
         end
      endcase
      warm_start = sw_start || stop_release;
   end

   // Configuration registers
   always_comb
   begin
      stby_nxt = stby_r;
      clk_nxt = clk_r;
      osc_nxt = osc_r;
      warm_slow_nxt = warm_slow_r;
      if (wr_take)
      begin
         case (avs_address)
            `STBY_CTRL_IDX:
               stby_nxt = sysclk_standby_pkg::standby_cfg_type'(avs_writedata[7:0] &
                  `STBY_CTRL_WMASK);
            `CLKOUT_CTRL_IDX:
               clk_nxt = sysclk_standby_pkg::clkout_cfg_type'(avs_writedata[7:0] &
                  `CLKOUT_CTRL_WMASK);
            `OSC_RUN_CTRL_IDX:
               osc_nxt = sysclk_standby_pkg::osc_cfg_type'(avs_writedata[7:0] &
                  `OSC_RUN_CTRL_WMASK);
            default: ;
         endcase
      end
      // Software warm-up times the oscillator that is not yet the source
      if (sw_start)
         warm_slow_nxt = !osc_r.sysclk_source_sel;
      if (stop_release)
      begin
         stby_nxt.fast_osc_low_drive = 1'b0;
         // Selected source comes back even if its after-stop bit was left at 0
         osc_nxt.fast_osc_enable = osc_r.fast_osc_after_stop ||
            !osc_r.sysclk_source_sel;
         osc_nxt.slow_osc_enable = osc_r.slow_osc_after_stop ||
            osc_r.sysclk_source_sel;
         warm_slow_nxt = osc_r.sysclk_source_sel;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         stby_r <= sysclk_standby_pkg::standby_cfg_type'(`STBY_CTRL_RST);
         clk_r <= sysclk_standby_pkg::clkout_cfg_type'(`CLKOUT_CTRL_RST);
         osc_r <= sysclk_standby_pkg::osc_cfg_type'(`OSC_RUN_CTRL_RST);
         state_r <= sysclk_standby_pkg::st_run;
         warm_slow_r <= 1'b0;
      end
      else
      begin
         stby_r <= stby_nxt;
         clk_r <= clk_nxt;
         osc_r <= osc_nxt;
         state_r <= state_nxt;
         warm_slow_r <= warm_slow_nxt;
      end
   end

   // Pin-side outputs, all registered
   always_comb
   begin
      div_nxt = div_r + 2'h1;
      fast_run_nxt = osc_r.fast_osc_enable && state_r != sysclk_standby_pkg::st_stop;
      slow_run_nxt = osc_r.slow_osc_enable && state_r != sysclk_standby_pkg::st_stop;
      pins_en_nxt = state_r != sysclk_standby_pkg::st_stop || stby_r.stop_pin_drive;
      // A flop cannot follow sys_clk itself; the fastest choice is one toggle per edge
      unique case (clk_r.clkout_sel)
         sysclk_standby_pkg::co_slow_gear: clkout_nxt = slow_level;
         sysclk_standby_pkg::co_sys_half: clkout_nxt = div_r[1];
         sysclk_standby_pkg::co_sys: clkout_nxt = div_r[0];
         sysclk_standby_pkg::co_prescale: clkout_nxt = prescaler_base_clock;
      endcase
      // System-derived clocks are parked low in sleep, stop and restart; stop parks the slow gear too
      if (state_r == sysclk_standby_pkg::st_stop ||
         (state_r != sysclk_standby_pkg::st_run && state_r != sysclk_standby_pkg::st_idle &&
         clk_r.clkout_sel != sysclk_standby_pkg::co_slow_gear))
         clkout_nxt = 1'b0;
      if (latch_req)
         latch_cnt_nxt = clk_r.latch_strobe_width ? 2'h2 : 2'h1;
      else if (latch_cnt_r != 2'h0)
         latch_cnt_nxt = latch_cnt_r - 2'h1;
      else
         latch_cnt_nxt = 2'h0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         div_r <= 2'h0;
         latch_cnt_r <= 2'h0;
         fast_run_r <= 1'b1;
         slow_run_r <= 1'b0;
         drive_r <= 1'b0;
         cpu_halt_r <= 1'b0;
         periph_halt_r <= 1'b0;
         pins_en_r <= 1'b1;
         clkout_r <= 1'b0;
         strobe_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         latch_cnt_r <= latch_cnt_nxt;
         fast_run_r <= fast_run_nxt;
         slow_run_r <= slow_run_nxt;
         drive_r <= stby_r.fast_osc_low_drive;
         cpu_halt_r <= state_r != sysclk_standby_pkg::st_run;
         periph_halt_r <= state_r == sysclk_standby_pkg::st_sleep ||
            state_r == sysclk_standby_pkg::st_stop || state_r == sysclk_standby_pkg::st_restart;
         pins_en_r <= pins_en_nxt;
         clkout_r <= clkout_nxt;
         strobe_r <= latch_cnt_nxt != 2'h0;
      end
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
   assign fast_osc_run = fast_run_r;
   assign slow_osc_run = slow_run_r;
   assign fast_osc_low_drive = drive_r;
   assign sysclk_source_sel = osc_r.sysclk_source_sel;
   assign cpu_halted = cpu_halt_r;
   assign periph_halted = periph_halt_r;
   assign pins_drive_en = pins_en_r;
   assign clock_output_pin = clkout_r;
   assign latch_strobe = strobe_r;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence s_stop_release;
      state_r == sysclk_standby_pkg::st_stop && wake_rise;
   endsequence

   property p_low_drive;
      wr_take && avs_address == `STBY_CTRL_IDX && avs_writedata[`STBY_LOW_DRIVE_BIT] &&
         state_r == sysclk_standby_pkg::st_run |=> ##1 fast_osc_low_drive;
   endproperty
   a_low_drive: assert property (p_low_drive) else $error("drive bit not applied");

   property p_enter_stop;
      state_r == sysclk_standby_pkg::st_run && core_wait && core_low_power_bit &&
         stby_r.standby_sel == sysclk_standby_pkg::sb_stop |=> ##1 cpu_halted && !fast_osc_run;
   endproperty
   a_enter_stop: assert property (p_enter_stop) else $error("STOP not entered");

   property p_no_entry;
      state_r == sysclk_standby_pkg::st_run && core_wait && !core_low_power_bit
         |=> state_r == sysclk_standby_pkg::st_run;
   endproperty
   a_no_entry: assert property (p_no_entry) else $error("standby without low-power bit");

   property p_pins_float;
      state_r == sysclk_standby_pkg::st_stop && !stby_r.stop_pin_drive |=> !pins_drive_en;
   endproperty
   a_pins_float: assert property (p_pins_float) else $error("pins driven in STOP");

   property p_strobe_long;
      latch_req && clk_r.latch_strobe_width ##1 !latch_req[*2] |-> latch_strobe ##1 !latch_strobe;
   endproperty
   a_strobe_long: assert property (p_strobe_long) else $error("two-cycle strobe wrong");

   property p_strobe_short;
      latch_req && !clk_r.latch_strobe_width ##1 !latch_req |-> latch_strobe ##1 !latch_strobe;
   endproperty
   a_strobe_short: assert property (p_strobe_short) else $error("one-cycle strobe wrong");

   property p_reserved_zero;
      avs_read && avs_waitrequest && avs_address == `CLKOUT_CTRL_IDX
         |=> avs_readdata[3:0] == 4'h0 && avs_readdata[31:7] == 25'h0000000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_drive_restored;
      s_stop_release |=> !stby_r.fast_osc_low_drive ##1 !fast_osc_low_drive;
   endproperty
   a_drive_restored: assert property (p_drive_restored) else $error("drive not restored");

   property p_source_restart;
      s_stop_release ##0 !osc_r.sysclk_source_sel |=> ##1 fast_osc_run;
   endproperty
   a_source_restart: assert property (p_source_restart) else $error("source not restarted");

   property p_flag_set;
      sw_start && stby_r.warmup_len != 2'h0 |=> warm_busy;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("warm-up flag not set");

   property p_sys_toggle;
      (clk_r.clkout_sel == sysclk_standby_pkg::co_sys &&
         state_r == sysclk_standby_pkg::st_run)[*3] |-> clock_output_pin != $past(clock_output_pin);
   endproperty
   a_sys_toggle: assert property (p_sys_toggle) else $error("clock output stalled");
endmodule // sysclk_standby_config

// ==== design/warmup_timer.sv ====
// Purpose: Oscillator warm-up counter, counting ticks of the oscillator being started
// Assumes: tick is a one-cycle pulse per oscillator period, already synchronised
// Notes: Length is latched at start so a later field change cannot shorten a run
`timescale 1ns/10ps
`include "sysclk_standby_map.svh"
module warmup_timer
#(
   parameter logic [16:0] ticks_mid = `WARMUP_TICKS_MID,
   parameter logic [16:0] ticks_long = `WARMUP_TICKS_LONG
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [1:0] len,
   input wire logic tick,
   output logic warm_busy
);
   logic [16:0] cnt_r, cnt_nxt;
   logic [16:0] term_r, term_nxt;
   logic busy_r, busy_nxt;

   function automatic logic [16:0] term_of(input logic [1:0] sel);
      case (sel)
         2'h1: term_of = `WARMUP_TICKS_SHORT;
         2'h2: term_of = ticks_mid;
         2'h3: term_of = ticks_long;
         default: term_of = 17'h00000;
      endcase
   endfunction

   always_comb
   begin
      cnt_nxt = cnt_r;
      term_nxt = term_r;
      busy_nxt = busy_r;
      // Restart beats completion in the same cycle
      if (start)
      begin
         cnt_nxt = 17'h00000;
         term_nxt = term_of(len);
         busy_nxt = (len != 2'h0);
      end
      else if (busy_r && tick)
      begin
         cnt_nxt = cnt_r + 17'h00001;
         if (cnt_nxt == term_r)
            busy_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         cnt_r <= 17'h00000;
         term_r <= 17'h00000;
         busy_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         term_r <= term_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign warm_busy = busy_r;

   property p_len_off;
      @(posedge sys_clk) disable iff (reset) start && len == 2'h0 |=> !busy_r;
   endproperty
   a_len_off: assert property (p_len_off) else $error("warm-up ran with length off");

   property p_terminal;
      @(posedge sys_clk) disable iff (reset)
         busy_r && tick && !start && (cnt_r + 17'h00001 == term_r) |=> !busy_r;
   endproperty
   a_terminal: assert property (p_terminal) else $error("warm-up missed terminal");

   property p_hold;
      @(posedge sys_clk) disable iff (reset) busy_r && !tick && !start |=> busy_r;
   endproperty
   a_hold: assert property (p_hold) else $error("warm-up ended without tick");
endmodule // warmup_timer

// ==== dv/sysclk_standby_config_test.sv ====
// Purpose: Self-checking bench for the clock/standby configuration block
// Assumes: Oscillator pins toggle only while the block runs that oscillator
// Notes: Warm-up mid/long counts shrunk to 8 and 16 ticks for a short run
`timescale 1ns/10ps
`include "sysclk_standby_map.svh"
module sysclk_standby_config_test;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [31:0] avs_address = 32'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic core_wait = 1'b0;
   logic core_low_power_bit = 1'b0;
   logic wake_pin = 1'b0;
   logic fast_pin = 1'b0;
   logic slow_pin = 1'b0;
   logic prescaler_base_clock = 1'b0;
   logic latch_req = 1'b0;
   logic fast_osc_run, slow_osc_run, fast_osc_low_drive, sysclk_source_sel;
   logic cpu_halted, periph_halted, pins_drive_en, clock_output_pin, latch_strobe;
   int err_total = 0;
   int check_count = 0;
   int n_len [4];
   logic [31:0] scratch;

   sysclk_standby_config #(.warmup_ticks_mid(17'h00008), .warmup_ticks_long(17'h00010))
   sysclk_standby_config_inst (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .core_wait(core_wait),
      .core_low_power_bit(core_low_power_bit), .wake_pin(wake_pin),
      .fast_osc_clk_pin(fast_pin), .slow_osc_clk_pin(slow_pin),
      .prescaler_base_clock(prescaler_base_clock), .latch_req(latch_req),
      .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run),
      .fast_osc_low_drive(fast_osc_low_drive), .sysclk_source_sel(sysclk_source_sel),
      .cpu_halted(cpu_halted), .periph_halted(periph_halted), .pins_drive_en(pins_drive_en),
      .clock_output_pin(clock_output_pin), .latch_strobe(latch_strobe));

   always #2.5 sys_clk = ~sys_clk;
   // Stopped oscillators hold low so no stale ticks leak into a warm-up
   always #5.5 fast_pin = fast_osc_run ? ~fast_pin : 1'b0;
   always #18.5 slow_pin = slow_osc_run ? ~slow_pin : 1'b0;

   task final_report;
      $display("Checks %0d, errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task timeout(input string name);
      err_total++;
      $display("ERROR %s expected done seen timeout", name);
      final_report();
   endtask

   task bus(input logic wr, input logic [31:0] addr, input logic [7:0] data,
      input logic [3:0] be, output logic [31:0] rd);
      int n;
      @(posedge sys_clk);
      avs_address <= addr;
      avs_writedata <= {24'h0, data};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge sys_clk);
      n = 0;
      while (avs_waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (avs_waitrequest !== 1'b0) timeout("waitrequest");
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task wr(input logic [31:0] addr, input logic [7:0] data);
      logic [31:0] d;
      bus(1'b1, addr, data, 4'h1, d);
   endtask

   task rd_chk(input string name, input logic [31:0] addr, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, addr, 8'h00, 4'h1, d);
      check(name, d, exp);
   endtask

   task warm(input logic [1:0] len, output int n);
      logic [31:0] d;
      wr(`STBY_CTRL_IDX, {2'b00, len, 4'hc});
      wr(`OSC_RUN_CTRL_IDX, 8'he4);
      n = 0;
      do
      begin
         bus(1'b0, `OSC_RUN_CTRL_IDX, 8'h00, 4'h1, d);
         n++;
      end
      while (d[2] === 1'b1 && n < 1000);
      if (d !== 32'he0) timeout("warmup_run_flag");
   endtask

   task co_changes(input logic [1:0] sel, input int exp);
      int c;
      logic last;
      wr(`CLKOUT_CTRL_IDX, {1'b0, sel, 5'h10});
      repeat (3) @(posedge sys_clk);
      last = clock_output_pin;
      c = 0;
      repeat (8)
      begin
         @(posedge sys_clk);
         c += (clock_output_pin !== last);
         last = clock_output_pin;
      end
      check("clkout_changes", c, exp);
   endtask

   task latch(input logic w, input int exp);
      int c;
      wr(`CLKOUT_CTRL_IDX, {3'b001, w, 4'h0});
      @(posedge sys_clk);
      latch_req <= 1'b1;
      @(posedge sys_clk);
      latch_req <= 1'b0;
      c = 0;
      repeat (5)
      begin
         @(posedge sys_clk);
         c += (latch_strobe === 1'b1);
      end
      check("latch_strobe_cycles", c, exp);
   endtask

   task standby(input logic [1:0] code, input logic lp, input logic pd, input logic halt);
      logic [7:0] img;
      int n;
      img = {4'b1010, code, 1'b0, pd};
      // Both oscillators on, after-stop bits and source select cleared in this write
      if (code == sysclk_standby_pkg::sb_stop) wr(`OSC_RUN_CTRL_IDX, 8'hc0);
      wr(`STBY_CTRL_IDX, img);
      // Drive output follows the register one edge later
      repeat (2) @(posedge sys_clk);
      check("fast_osc_low_drive", fast_osc_low_drive, 1);
      core_low_power_bit <= lp;
      core_wait <= 1'b1;
      @(posedge sys_clk);
      core_wait <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("cpu_halted", cpu_halted, halt);
      if (halt)
      begin
         check("periph_halted", periph_halted, code != sysclk_standby_pkg::sb_idle);
         check("pins_drive_en", pins_drive_en, pd || code != 2'h1);
         wake_pin <= 1'b1;
         n = 0;
         while (cpu_halted !== 1'b0 && n < 3000)
         begin
            @(posedge sys_clk);
            n++;
         end
         if (cpu_halted !== 1'b0) timeout("wake");
         wake_pin <= 1'b0;
         check("fast_osc_run", fast_osc_run, 1);
         check("fast_osc_low_drive", fast_osc_low_drive, code != 2'h1);
         rd_chk("standby_reg", `STBY_CTRL_IDX, code == 2'h1 ? img & 8'h7f : img);
         if (code == 2'h1) rd_chk("osc_reg", `OSC_RUN_CTRL_IDX, 32'h80);
      end
      core_low_power_bit <= 1'b0;
   endtask

   initial
   begin
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      check("fast_osc_low_drive", fast_osc_low_drive, 0);
      check("pins_drive_en", pins_drive_en, 1);
      check("sysclk_source_sel", sysclk_source_sel, 0);
      rd_chk("standby_reg", `STBY_CTRL_IDX, 32'h2c);
      rd_chk("clkout_reg", `CLKOUT_CTRL_IDX, 32'h30);
      rd_chk("osc_reg", `OSC_RUN_CTRL_IDX, 32'ha0);
      wr(`STBY_CTRL_IDX, 8'hff);
      rd_chk("standby_reg", `STBY_CTRL_IDX, 32'hbd);
      bus(1'b1, `STBY_CTRL_IDX, 8'h00, 4'h0, scratch);
      rd_chk("standby_reg", `STBY_CTRL_IDX, 32'hbd);
      wr(`CLKOUT_CTRL_IDX, 8'hff);
      rd_chk("clkout_reg", `CLKOUT_CTRL_IDX, 32'h70);
      wr(32'hffffee20, 8'hff);
      rd_chk("unmapped", 32'hffffee20, 32'h0);
      latch(1'b1, 2);
      latch(1'b0, 1);
      co_changes(2'b10, 8);
      co_changes(2'b01, 4);
      prescaler_base_clock <= 1'b1;
      co_changes(2'b11, 0);
      check("clock_output_pin", clock_output_pin, 1);
      wr(`OSC_RUN_CTRL_IDX, 8'he4);
      wr(`OSC_RUN_CTRL_IDX, 8'he0);
      rd_chk("osc_reg", `OSC_RUN_CTRL_IDX, 32'he4);
      for (int i = 0; i < 4; i++) warm(i[1:0], n_len[i]);
      check("no_warmup", n_len[0] < 3, 1);
      check("warmup_order", n_len[3] > n_len[2] + n_len[2] / 2, 1);
      check("warmup_short", n_len[1] > n_len[3], 1);
      standby(2'h3, 1'b0, 1'b0, 1'b0);
      standby(2'h0, 1'b1, 1'b0, 1'b0);
      standby(2'h3, 1'b1, 1'b0, 1'b1);
      standby(2'h2, 1'b1, 1'b0, 1'b1);
      standby(2'h1, 1'b1, 1'b1, 1'b1);
      standby(2'h1, 1'b1, 1'b0, 1'b1);
      final_report();
   end
endmodule // sysclk_standby_config_test

// ==== pkg/sysclk_standby_map.svh ====
// Purpose: Offsets, field positions, reset images and warm-up counts for the clock/standby block
// Assumes: Avalon word address equals the register index; byte address is four times it
// Notes: Register images are 8 bits wide and sit in byte lane 0
`ifndef SYSCLK_STANDBY_MAP_SVH
`define SYSCLK_STANDBY_MAP_SVH

// Register indices (word addresses)
`define STBY_CTRL_IDX 32'hffffee02
`define CLKOUT_CTRL_IDX 32'hffffee03
`define OSC_RUN_CTRL_IDX 32'hffffee10

// oscillator_standby_ctrl fields
`define STBY_LOW_DRIVE_BIT 7
`define STBY_WUP_LO 4
`define STBY_SEL_LO 2
`define STBY_PIN_DRIVE_BIT 0
`define STBY_CTRL_RST 8'h2c
`define STBY_CTRL_WMASK 8'hbd

// clock_output_ctrl fields
`define CLKOUT_SEL_LO 5
`define CLKOUT_LATCH_BIT 4
`define CLKOUT_CTRL_RST 8'h30
`define CLKOUT_CTRL_WMASK 8'h70

// osc_run_ctrl fields
`define OSC_FAST_EN_BIT 7
`define OSC_SLOW_EN_BIT 6
`define OSC_WARM_FLAG_BIT 2
`define OSC_SRC_SEL_BIT 0
`define OSC_RUN_CTRL_RST 8'ha0
`define OSC_RUN_CTRL_WMASK 8'hf1

// Warm-up lengths in oscillator ticks
`define WARMUP_TICKS_SHORT 17'h00100
`define WARMUP_TICKS_MID 17'h04000
`define WARMUP_TICKS_LONG 17'h10000

`endif

// ==== pkg/sysclk_standby_pkg.sv ====
// Purpose: Types shared by the clock/standby block
// Assumes: Structs mirror the 8-bit register images bit for bit
// Notes: Reserved fields are kept so a register image casts straight in
package sysclk_standby_pkg;

   typedef enum logic [1:0] {sb_reserved = 2'h0, sb_stop = 2'h1, sb_sleep = 2'h2,
      sb_idle = 2'h3} standby_code_type;

   typedef enum logic [1:0] {co_slow_gear = 2'h0, co_sys_half = 2'h1, co_sys = 2'h2,
      co_prescale = 2'h3} clkout_code_type;

   typedef enum {st_run, st_idle, st_sleep, st_stop, st_restart} power_state_type;

   typedef struct packed {
      logic fast_osc_low_drive;
      logic rsv6;
      logic [1:0] warmup_len;
      standby_code_type standby_sel;
      logic rsv1;
      logic stop_pin_drive;
   } standby_cfg_type;

   typedef struct packed {
      logic rsv7;
      clkout_code_type clkout_sel;
      logic latch_strobe_width;
      logic [3:0] rsv;
   } clkout_cfg_type;

   typedef struct packed {
      logic fast_osc_enable;
      logic slow_osc_enable;
      logic fast_osc_after_stop;
      logic slow_osc_after_stop;
      logic [2:0] rsv;
      logic sysclk_source_sel;
   } osc_cfg_type;

endpackage
